// >>> rtl/hrap_device.sv
// Purpose: Device end: register file reached by serial or parallel host access
// Assumes: Host pins are asynchronous and pass a three-stage filter
// Notes: Serial write commits on the last data bit; serial wins a write clash
`default_nettype none
module hrap_device (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Link to host
  hrap_if.device link,
  // Parallel bus style strap
  input wire hrap_pkg::hrap_bus_e bus_mode,
  // Register update report
  output logic upd_stb,
  output logic [hrap_pkg::ADDR_BITS-1:0] upd_addr,
  output logic [hrap_pkg::DATA_BITS-1:0] upd_data
);
  import hrap_pkg::*;
  localparam int NSYNC = 9 + ADDR_BITS + DATA_BITS;
  localparam int WORDS = 2 ** ADDR_BITS;
  localparam logic [4:0] HDR = 5'(INSTR_BITS + ADDR_BITS);
  localparam logic [4:0] LAST = 5'(FRAME_BITS - 1);
  localparam logic [4:0] FULL = 5'(FRAME_BITS);
  typedef enum logic [0:0] {P_IDLE = 1'b0, P_ACK = 1'b1} hrap_pst_e;

  logic [NSYNC-1:0] pin_raw, sy1, sy2, sy3, lvl, next_lvl;
  logic cs_f, sclk_f, ser_in_f, pcs_f, dstb_f, rw_f, rd_f, wr_f, als_f, sclk_d, sclk_rise, sclk_fall;
  logic [ADDR_BITS-1:0] addr_f, mux_addr, next_mux, p_addr, s_wa, m_wa;
  logic [DATA_BITS-1:0] data_f, sout, next_sout, dd, next_dd, s_wd, m_wd;
  logic [DATA_BITS-1:0] mem [0:WORDS-1];
  logic [FRAME_BITS-2:0] sin, next_sin;
  logic [4:0] cnt, next_cnt;
  logic rd_op, next_rd, obit, next_obit, soe, next_soe, s_we, p_we, m_we;
  logic p_act, p_rd, ack, next_ack, doe, next_doe;
  hrap_pst_e pst, next_pst;

  // Pin filter: a level counts once stages two and three agree
  assign pin_raw = {link.cs_n, link.sclk, link.serial_in_line, link.par_cs_n, link.data_strobe_n,
    link.rd_wr, link.rd_n, link.wr_n, link.address_latch_strobe, link.addr, link.data};
  assign next_lvl = (sy2 & sy3) | (lvl & (sy2 | sy3));
  assign {cs_f, sclk_f, ser_in_f, pcs_f, dstb_f, rw_f, rd_f, wr_f, als_f, addr_f, data_f} = lvl;
  assign sclk_rise = sclk_f & ~sclk_d;
  assign sclk_fall = ~sclk_f & sclk_d;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1 <= {DEV_CTRL_IDLE, {(ADDR_BITS + DATA_BITS){1'b0}}};
      sy2 <= {DEV_CTRL_IDLE, {(ADDR_BITS + DATA_BITS){1'b0}}};
      sy3 <= {DEV_CTRL_IDLE, {(ADDR_BITS + DATA_BITS){1'b0}}};
      lvl <= {DEV_CTRL_IDLE, {(ADDR_BITS + DATA_BITS){1'b0}}};
    end else begin
      sy1 <= pin_raw;
      sy2 <= sy1;
      sy3 <= sy2;
      lvl <= next_lvl;
    end
  end

  // Serial frame: instruction, address, data
  always_comb begin
    next_cnt = cnt;
    next_sin = sin;
    next_rd = rd_op;
    next_sout = sout;
    next_obit = obit;
    next_soe = soe;
    s_we = 1'b0;
    s_wa = sin[DATA_BITS+ADDR_BITS-2:DATA_BITS-1];
    s_wd = {sin[DATA_BITS-2:0], ser_in_f};
    if (cs_f) begin
      next_cnt = 5'h00;
      next_soe = 1'b0;
    end else begin
      if (sclk_rise && cnt != FULL) begin
        next_sin = {sin[FRAME_BITS-3:0], ser_in_f};
        next_cnt = cnt + 5'h01;
        if (cnt == 5'h00)
          next_rd = ser_in_f;
        if (cnt == HDR - 5'h01)
          next_sout = mem[{sin[ADDR_BITS-2:0], ser_in_f}];
        if (cnt == LAST && !rd_op)
          s_we = 1'b1;
      end
      if (sclk_fall && rd_op && cnt >= HDR && cnt <= LAST) begin
        next_obit = sout[DATA_BITS-1];
        next_sout = {sout[DATA_BITS-2:0], 1'b0};
        next_soe = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 5'h00;
      sin <= '0;
      rd_op <= 1'b0;
      sout <= 8'h00;
      obit <= 1'b1;
      soe <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sin <= next_sin;
      rd_op <= next_rd;
      sout <= next_sout;
      obit <= next_obit;
      soe <= next_soe;
      sclk_d <= sclk_f;
    end
  end

  // Parallel strobes, address latch and acknowledge
  always_comb begin
    p_act = 1'b0;
    p_rd = rw_f;
    case (bus_mode)
      BUS_SEP: begin
        p_act = !pcs_f && (!rd_f || !wr_f);
        p_rd = !rd_f;
      end
      BUS_DSTB, BUS_MUX: p_act = !pcs_f && !dstb_f;
      default: p_act = 1'b0;
    endcase
    p_addr = (bus_mode == BUS_MUX) ? mux_addr : addr_f;
    next_mux = als_f ? {addr_f[ADDR_BITS-1:DATA_BITS], data_f} : mux_addr;
    next_pst = pst;
    next_ack = ack;
    next_dd = dd;
    next_doe = doe;
    p_we = 1'b0;
    case (pst)
      P_IDLE: if (p_act) begin
        next_pst = P_ACK;
        if (p_rd) begin
          next_dd = mem[p_addr];
          next_doe = 1'b1;
        end else begin
          p_we = 1'b1;
        end
      end
      P_ACK: if (!p_act) begin
        next_pst = P_IDLE;
        next_ack = 1'b0;
        next_doe = 1'b0;
      end else begin
        next_ack = 1'b1;
      end
      default: next_pst = P_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pst <= P_IDLE;
      ack <= 1'b0;
      dd <= 8'h00;
      doe <= 1'b0;
      mux_addr <= 11'h000;
    end else begin
      pst <= next_pst;
      ack <= next_ack;
      dd <= next_dd;
      doe <= next_doe;
      mux_addr <= next_mux;
    end
  end

  // Register file write port, serial first
  always_comb begin
    m_we = s_we | p_we;
    m_wa = s_we ? s_wa : p_addr;
    m_wd = s_we ? s_wd : data_f;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= REG_RESET;
      end
      upd_stb <= 1'b0;
      upd_addr <= 11'h000;
      upd_data <= 8'h00;
    end else begin
      if (m_we)
        mem[m_wa] <= m_wd;
      upd_stb <= m_we;
      upd_addr <= m_wa;
      upd_data <= m_wd;
    end
  end

  // Pins toward the host
  assign link.ser_out_bit = obit;
  assign link.ser_out_oe = soe;
  assign link.access_ack = ack;
  assign link.dev_d = dd;
  assign link.dev_doe = doe;
endmodule
`default_nettype wire

// >>> rtl/hrap_host.sv
// Purpose: Host end: runs one register access over serial or a parallel bus
// Assumes: Device answers pass a three-stage filter; shift clock made here
// Notes: Strobes are held until acknowledge and for at least the least widths
`default_nettype none
module hrap_host #(
  parameter int SCLK_HALF_CYC = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Link to device
  hrap_if.host link,
  // Access request
  input wire logic req,
  input wire hrap_pkg::hrap_bus_e req_bus,
  input wire logic req_read,
  input wire logic [hrap_pkg::ADDR_BITS-1:0] req_addr,
  input wire logic [hrap_pkg::DATA_BITS-1:0] req_wdata,
  // Access result
  output logic busy,
  output logic done,
  output logic [hrap_pkg::DATA_BITS-1:0] rdata
);
  import hrap_pkg::*;
  typedef enum logic [3:0] {
    H_IDLE = 4'h0,
    H_CS_SETUP = 4'h1,
    H_SLOW = 4'h2,
    H_SHIGH = 4'h3,
    H_CS_HOLD = 4'h4,
    H_CS_HIGH = 4'h5,
    H_ALS = 4'h6,
    H_SETUP = 4'h7,
    H_STROBE = 4'h8,
    H_RELEASE = 4'h9
  } hrap_hst_e;
  localparam logic [7:0] HALF_END = 8'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] HDR = 5'(INSTR_BITS + ADDR_BITS);
  localparam logic [4:0] LAST = 5'(FRAME_BITS - 1);
  // Latch strobe stands long enough to pass the far pin filter
  localparam logic [7:0] ALS_END = 8'(((ALS_CYC < FILT_MIN_CYC) ? FILT_MIN_CYC : ALS_CYC) - 1);

  logic [DATA_BITS+1:0] in_raw, sy1, sy2, sy3, lvl, next_lvl;
  logic sout_f, ack_f;
  logic [DATA_BITS-1:0] data_f;
  hrap_hst_e st, next_st;
  hrap_pins_s pins, next_pins;
  logic [7:0] cnt, next_cnt, strobe_min;
  logic [4:0] bitn, next_bitn;
  logic [FRAME_BITS-1:0] frame, next_frame;
  logic [DATA_BITS-1:0] rbuf, next_rbuf, next_rdata, wdata, next_wdata;
  hrap_bus_e op_bus, next_op_bus;
  logic op_read, next_op_read, next_busy, next_done;

  // Filter on device answers
  assign in_raw = {link.serial_out_line, link.access_ack, link.data};
  assign next_lvl = (sy2 & sy3) | (lvl & (sy2 | sy3));
  assign {sout_f, ack_f, data_f} = lvl;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1 <= HOST_IN_IDLE;
      sy2 <= HOST_IN_IDLE;
      sy3 <= HOST_IN_IDLE;
      lvl <= HOST_IN_IDLE;
    end else begin
      sy1 <= in_raw;
      sy2 <= sy1;
      sy3 <= sy2;
      lvl <= next_lvl;
    end
  end

  // Least strobe width for the running access
  always_comb begin
    if (!op_read)
      strobe_min = 8'(WR_CYC);
    else if (op_bus == BUS_SEP)
      strobe_min = 8'(RD_SEP_CYC);
    else
      strobe_min = 8'(RD_DSTB_CYC);
  end

  // Access sequencer
  always_comb begin
    next_st = st;
    next_pins = pins;
    next_cnt = (cnt != 8'hff) ? cnt + 8'h01 : cnt;
    next_bitn = bitn;
    next_frame = frame;
    next_rbuf = rbuf;
    next_rdata = rdata;
    next_wdata = wdata;
    next_op_bus = op_bus;
    next_op_read = op_read;
    next_busy = busy;
    next_done = 1'b0;
    case (st)
      H_IDLE: begin
        next_cnt = 8'h00;
        if (req) begin
          next_busy = 1'b1;
          next_op_bus = req_bus;
          next_op_read = req_read;
          next_wdata = req_wdata;
          next_frame = {req_read ? INSTR_READ : INSTR_WRITE, req_addr, req_read ? 8'h00 : req_wdata};
          if (req_bus == BUS_SERIAL) begin
            next_pins.cs_n = 1'b0;
            next_st = H_CS_SETUP;
          end else begin
            next_pins.addr = req_addr;
            next_pins.rw = req_read;
            next_pins.als = (req_bus == BUS_MUX);
            next_pins.hd = (req_bus == BUS_MUX) ? req_addr[DATA_BITS-1:0] : req_wdata;
            next_pins.hdoe = (req_bus == BUS_MUX) || !req_read;
            next_st = (req_bus == BUS_MUX) ? H_ALS : H_SETUP;
          end
        end
      end
      H_CS_SETUP: if (cnt == 8'(CS_SETUP_CYC - 1)) begin
        next_pins.ser_in = frame[FRAME_BITS-1];
        next_frame = {frame[FRAME_BITS-2:0], 1'b0};
        next_bitn = 5'h00;
        next_cnt = 8'h00;
        next_st = H_SLOW;
      end
      H_SLOW: if (cnt == HALF_END) begin
        next_pins.sclk = 1'b1;
        next_cnt = 8'h00;
        next_st = H_SHIGH;
      end
      H_SHIGH: if (cnt == HALF_END) begin
        if (op_read && bitn >= HDR)
          next_rbuf = {rbuf[DATA_BITS-2:0], sout_f};
        next_pins.sclk = 1'b0;
        next_cnt = 8'h00;
        if (bitn == LAST) begin
          next_st = H_CS_HOLD;
        end else begin
          next_pins.ser_in = frame[FRAME_BITS-1];
          next_frame = {frame[FRAME_BITS-2:0], 1'b0};
          next_bitn = bitn + 5'h01;
          next_st = H_SLOW;
        end
      end
      H_CS_HOLD: if (cnt == 8'(CS_HOLD_CYC - 1)) begin
        next_pins.cs_n = 1'b1;
        next_cnt = 8'h00;
        next_st = H_CS_HIGH;
      end
      H_CS_HIGH: if (cnt == 8'(CS_HIGH_CYC - 1)) begin
        if (op_read)
          next_rdata = rbuf;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_st = H_IDLE;
      end
      H_ALS: if (cnt == ALS_END) begin
        next_pins.als = 1'b0;
        next_st = H_SETUP;
      end
      H_SETUP: begin
        next_pins.pcs_n = 1'b0;
        if (op_bus == BUS_SEP) begin
          next_pins.rd_n = !op_read;
          next_pins.wr_n = op_read;
        end else begin
          next_pins.dstb_n = 1'b0;
        end
        if (op_bus == BUS_MUX) begin
          next_pins.hd = wdata;
          next_pins.hdoe = !op_read;
        end
        next_cnt = 8'h00;
        next_st = H_STROBE;
      end
      H_STROBE: if (ack_f && cnt + 8'h01 >= strobe_min) begin
        if (op_read)
          next_rdata = data_f;
        next_pins.pcs_n = 1'b1;
        next_pins.dstb_n = 1'b1;
        next_pins.rd_n = 1'b1;
        next_pins.wr_n = 1'b1;
        next_st = H_RELEASE;
      end
      H_RELEASE: begin
        next_pins.hdoe = 1'b0;
        next_pins.rw = 1'b1;
        if (!ack_f) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st = H_IDLE;
        end
      end
      default: next_st = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= H_IDLE;
      pins <= HOST_PINS_IDLE;
      cnt <= 8'h00;
      bitn <= 5'h00;
      frame <= '0;
      rbuf <= 8'h00;
      rdata <= 8'h00;
      wdata <= 8'h00;
      op_bus <= BUS_SERIAL;
      op_read <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      st <= next_st;
      pins <= next_pins;
      cnt <= next_cnt;
      bitn <= next_bitn;
      frame <= next_frame;
      rbuf <= next_rbuf;
      rdata <= next_rdata;
      wdata <= next_wdata;
      op_bus <= next_op_bus;
      op_read <= next_op_read;
      busy <= next_busy;
      done <= next_done;
    end
  end

  // Pins toward the device
  assign link.cs_n = pins.cs_n;
  assign link.sclk = pins.sclk;
  assign link.serial_in_line = pins.ser_in;
  assign link.par_cs_n = pins.pcs_n;
  assign link.data_strobe_n = pins.dstb_n;
  assign link.rd_wr = pins.rw;
  assign link.rd_n = pins.rd_n;
  assign link.wr_n = pins.wr_n;
  assign link.address_latch_strobe = pins.als;
  assign link.addr = pins.addr;
  assign link.host_d = pins.hd;
  assign link.host_doe = pins.hdoe;
endmodule
`default_nettype wire

// >>> rtl/hrap_if.sv
// Purpose: Pins between host and device register access ends
// Assumes: Shared data bus pulled high when nobody drives it
// Notes: Resolves the two-way data bus and the serial output from the enables
`default_nettype none
interface hrap_if;
  logic cs_n, sclk, serial_in_line, ser_out_bit, ser_out_oe, serial_out_line;
  logic par_cs_n, data_strobe_n, rd_wr, rd_n, wr_n, address_latch_strobe, access_ack;
  logic [hrap_pkg::ADDR_BITS-1:0] addr;
  logic [hrap_pkg::DATA_BITS-1:0] host_d, dev_d, data;
  logic host_doe, dev_doe;

  // Wire levels from the drivers
  assign serial_out_line = ser_out_oe ? ser_out_bit : 1'b1;
  assign data = host_doe ? host_d : (dev_doe ? dev_d : 8'hff);

  modport host(output cs_n, sclk, serial_in_line, par_cs_n, data_strobe_n, rd_wr, rd_n, wr_n,
    address_latch_strobe, addr, host_d, host_doe, input serial_out_line, access_ack, data);
  modport device(input cs_n, sclk, serial_in_line, par_cs_n, data_strobe_n, rd_wr, rd_n, wr_n,
    address_latch_strobe, addr, data, output ser_out_bit, ser_out_oe, access_ack, dev_d, dev_doe);
endinterface
`default_nettype wire

// >>> rtl/hrap_pkg.sv
// Purpose: Shared constants and types for the host register access port
// Assumes: Both ends run core_clk at 10 MHz
// Notes: Times are in ns; cycle counts are derived from them
`default_nettype none
package hrap_pkg;
  localparam int CLK_MHZ = 10;
  localparam int INSTR_BITS = 5;
  localparam int ADDR_BITS = 11;
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = INSTR_BITS + ADDR_BITS + DATA_BITS;
  // Instruction codes, direction in the MSB
  localparam logic [4:0] INSTR_READ = 5'h10;
  localparam logic [4:0] INSTR_WRITE = 5'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Idle device pin levels: cs sclk ser_in pcs dstb rw rd wr als
  localparam logic [8:0] DEV_CTRL_IDLE = 9'h13e;
  // Idle host pin levels: ser_out ack data
  localparam logic [9:0] HOST_IN_IDLE = 10'h200;
  // Pin times
  localparam int T_RD_DSTB_NS = 38;
  localparam int T_RD_SEP_NS = 33;
  localparam int T_WR_NS = 5;
  localparam int T_ALS_NS = 5;
  localparam int T_SCLK_HALF_NS = 205;
  localparam int T_CS_SETUP_NS = 50;
  localparam int T_CS_HOLD_NS = 100;
  localparam int T_CS_HIGH_NS = 100;

  // Least time to whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RD_DSTB_CYC = ns2cyc(T_RD_DSTB_NS);
  localparam int RD_SEP_CYC = ns2cyc(T_RD_SEP_NS);
  localparam int WR_CYC = ns2cyc(T_WR_NS);
  localparam int ALS_CYC = ns2cyc(T_ALS_NS);
  localparam int SCLK_MIN_CYC = ns2cyc(T_SCLK_HALF_NS);
  localparam int CS_SETUP_CYC = ns2cyc(T_CS_SETUP_NS);
  localparam int CS_HOLD_CYC = ns2cyc(T_CS_HOLD_NS);
  localparam int CS_HIGH_CYC = ns2cyc(T_CS_HIGH_NS);
  // Least pin level width that the three-stage filter passes
  localparam int FILT_MIN_CYC = 2;

  typedef enum logic [1:0] {
    BUS_SERIAL = 2'h0,
    BUS_DSTB = 2'h1,
    BUS_SEP = 2'h2,
    BUS_MUX = 2'h3
  } hrap_bus_e;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic ser_in;
    logic pcs_n;
    logic dstb_n;
    logic rw;
    logic rd_n;
    logic wr_n;
    logic als;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] hd;
    logic hdoe;
  } hrap_pins_s;

  localparam hrap_pins_s HOST_PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, ser_in: 1'b0, pcs_n: 1'b1, dstb_n: 1'b1,
    rw: 1'b1, rd_n: 1'b1, wr_n: 1'b1, als: 1'b0, addr: 11'h000, hd: 8'h00, hdoe: 1'b0};
endpackage
`default_nettype wire

// >>> testbench/hrap_monitor.sv
// Purpose: Checker on the link wires between host and device ends
// Assumes: One clock; link pins change only just after core_clk edges
// Notes: Delay bounds leave room for the three-stage pin filters
`default_nettype none
module hrap_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic ser_out_bit,
  input wire logic ser_out_oe,
  // Parallel wires
  input wire logic par_cs_n,
  input wire logic data_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic address_latch_strobe,
  input wire logic access_ack
);
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;

  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Count shift clock rises inside one frame
  always_comb begin
    next_bit_cnt = bit_cnt;
    if (cs_n) begin
      next_bit_cnt = 5'h00;
    end else if (sclk && !sclk_q) begin
      next_bit_cnt = bit_cnt + 5'h01;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      bit_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      bit_cnt <= next_bit_cnt;
    end
  end

  // Parallel access phases
  sequence strobe_on;
    !par_cs_n && (!data_strobe_n || !rd_n || !wr_n);
  endsequence
  sequence addr_latched;
    $fell(address_latch_strobe);
  endsequence

  a_sclk_in_frame: assert property ($rose(sclk) |-> !cs_n)
    else $error("shift clock rose outside a frame");
  a_sout_release: assert property ($rose(cs_n) |-> ##[0:6] !ser_out_oe)
    else $error("serial output still driven after frame end");
  a_sdi_hold_high: assert property (sclk && $past(sclk) |-> $stable(serial_in_line))
    else $error("serial input moved while shift clock high");
  a_frame_length: assert property ($rose(cs_n) |-> bit_cnt == 5'h18)
    else $error("frame did not carry 24 bits");
  a_sout_on_low: assert property (ser_out_oe && $past(ser_out_oe) && $changed(ser_out_bit) |-> !sclk)
    else $error("serial output changed while shift clock high");
  a_ack_answers: assert property ($fell(par_cs_n) |-> ##[2:10] access_ack)
    else $error("no acknowledge after strobe");
  a_ack_release: assert property ($rose(par_cs_n) |-> ##[1:8] !access_ack)
    else $error("acknowledge stuck after strobe end");
  a_strobe_held: assert property (strobe_on ##0 !access_ack |=> !par_cs_n)
    else $error("strobe ended before acknowledge");
  a_sep_wr_idle: assert property (!rd_n |-> wr_n)
    else $error("write strobe low during read");
  a_sep_rd_idle: assert property (!wr_n |-> rd_n)
    else $error("read strobe low during write");
  a_mux_addr_first: assert property (addr_latched |-> ##[1:2] ($fell(data_strobe_n) && !par_cs_n))
    else $error("data strobe did not follow address latch");
  a_latch_no_strobe: assert property (address_latch_strobe |-> data_strobe_n)
    else $error("data strobe low while address latched");
endmodule
`default_nettype wire

// >>> testbench/tb_host_register_access_port.sv
// Purpose: Bench joining host and device ends through the link
// Assumes: Clock 10 MHz; strap set to the style of each access
// Notes: Random writes and read-backs over all four bus styles
`default_nettype none
module tb_host_register_access_port;
  timeunit 1ns;
  timeprecision 1ns;
  import hrap_pkg::*;
  logic core_clk, rst_b, req, req_read, busy, done, upd_stb, sclk_q, cs_q;
  hrap_bus_e req_bus, bus_mode;
  logic [ADDR_BITS-1:0] req_addr, upd_addr, last_a;
  logic [DATA_BITS-1:0] req_wdata, rdata, upd_data, last_d;
  logic [DATA_BITS-1:0] mem [2**ADDR_BITS];
  logic [23:0] frame_seen;
  int fails, samples_checked;
  int upd_cnt = 0;
  int bits_seen = 0;

  hrap_if hrap_if_i ();
  // Half period long enough that read data settles while the shift clock is low
  hrap_host #(.SCLK_HALF_CYC(8)) hrap_host_i (.core_clk(core_clk), .rst_b(rst_b), .link(hrap_if_i.host),
    .req(req), .req_bus(req_bus), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
    .busy(busy), .done(done), .rdata(rdata));
  hrap_device hrap_device_i (.core_clk(core_clk), .rst_b(rst_b), .link(hrap_if_i.device), .bus_mode(bus_mode),
    .upd_stb(upd_stb), .upd_addr(upd_addr), .upd_data(upd_data));
  hrap_monitor hrap_monitor_i (.core_clk(core_clk), .rst_b(rst_b), .cs_n(hrap_if_i.cs_n), .sclk(hrap_if_i.sclk),
    .serial_in_line(hrap_if_i.serial_in_line), .ser_out_bit(hrap_if_i.ser_out_bit),
    .ser_out_oe(hrap_if_i.ser_out_oe),
    .par_cs_n(hrap_if_i.par_cs_n), .data_strobe_n(hrap_if_i.data_strobe_n), .rd_n(hrap_if_i.rd_n),
    .wr_n(hrap_if_i.wr_n), .address_latch_strobe(hrap_if_i.address_latch_strobe),
    .access_ack(hrap_if_i.access_ack));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Rebuild serial frames and note register updates
  always @(posedge core_clk) begin
    sclk_q <= hrap_if_i.sclk;
    cs_q <= hrap_if_i.cs_n;
    if (!hrap_if_i.cs_n && cs_q) begin
      bits_seen <= 0;
    end else if (hrap_if_i.sclk && !sclk_q) begin
      frame_seen <= {frame_seen[22:0], hrap_if_i.serial_in_line};
      bits_seen <= bits_seen + 1;
    end
    if (upd_stb === 1'b1) begin
      upd_cnt <= upd_cnt + 1;
      last_a <= upd_addr;
      last_d <= upd_data;
    end
  end

  // Instruction and address expected at the head of a frame
  function automatic logic [15:0] frame_head(input logic rd, input logic [ADDR_BITS-1:0] a);
    return {rd ? INSTR_READ : INSTR_WRITE, a};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One access from request to done, then its checks
  task automatic access(input hrap_bus_e bus, input logic rd, input logic [ADDR_BITS-1:0] a,
    input logic [DATA_BITS-1:0] d);
    int n;
    int u;
    u = upd_cnt;
    n = 0;
    @(posedge core_clk);
    bus_mode <= bus;
    req <= 1'b1;
    req_bus <= bus;
    req_read <= rd;
    req_addr <= a;
    req_wdata <= d;
    @(posedge core_clk);
    req <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 2000);
    if (n >= 2000) fails++;
    check(busy, 1'b0);
    if (rd) begin
      check(rdata, mem[a]);
      check(upd_cnt, u);
    end else begin
      mem[a] = d;
      check(upd_cnt, u + 1);
      check({last_a, last_d}, {a, d});
    end
    if (bus == BUS_SERIAL) begin
      check(bits_seen, 24);
      check(rd ? frame_seen[23:8] : frame_seen, rd ? frame_head(rd, a) : {frame_head(rd, a), d});
    end
  endtask

  // Main sequence
  initial begin
    logic [ADDR_BITS-1:0] a;
    logic [DATA_BITS-1:0] d;
    rst_b = 1'b0;
    req = 1'b0;
    req_bus = BUS_SERIAL;
    bus_mode = BUS_SERIAL;
    req_read = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    fails = 0;
    samples_checked = 0;
    foreach (mem[i]) mem[i] = REG_RESET;
    void'($urandom(32'ha3471c7c));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    access(BUS_SERIAL, 1'b1, 11'h555, 8'h00);
    // Corner values first, then random; writes cycle through every style
    for (int i = 0; i < 32; i++) begin
      a = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : ADDR_BITS'($urandom);
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : DATA_BITS'($urandom);
      access(hrap_bus_e'(i % 4), 1'b0, a, d);
      access(hrap_bus_e'($urandom_range(3, 0)), 1'b1, a, 8'h00);
    end
    summarize();
  end

  // Watchdog: a few times the longest expected run of 65 accesses
  initial begin
    #4000000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
